// ==== src/pwsi_pkg.sv ====
package pwsi_pkg;

  // Interleave register map
  localparam logic [7:0] ILV_REG_ADDR    = 8'h04;
  localparam logic [7:0] ILV_REG_RESET   = 8'h00;
  localparam int         ILV_CODE_LSB    = 0;
  localparam int         ILV_CODE_W      = 4;
  localparam int         ILV_FREQ_BIT    = 5;
  localparam int         ILV_PHS_LSB     = 6;
  localparam int         ILV_PHASE_SHIFT = 4;

  // Serial slave address, value is arbitrary
  localparam logic [6:0] I2C_DEV_ADDR_DFLT = 7'h2A;

  // Timing
  localparam int CORE_FREQ_KHZ   = 10000;
  localparam int SYNC_FREQ_KHZ   = 500;
  localparam int FAST_FREQ_KHZ   = 1000;
  localparam int SYNC_PERIOD_CYC = CORE_FREQ_KHZ / SYNC_FREQ_KHZ;
  localparam int DUTY_SHIFT      = 8;

  // Turn-off kinds carried on the group line
  typedef enum logic [1:0] {
    OFF_SEQ  = 2'h0,
    OFF_CRIT = 2'h1,
    OFF_EMRG = 2'h2
  } pwsi_off_t;

  typedef struct packed {
    logic tw;
    logic pg;
    logic tr;
    logic ot;
    logic oc;
    logic uv;
    logic ov;
  } pwsi_mon_t;

  typedef struct packed {
    logic vin_ok;
    logic ramp;
    logic steady;
    logic above_prebias;
  } pwsi_stage_t;

  typedef struct packed {
    logic                  fast;
    logic [ILV_CODE_W-1:0] code;
  } pwsi_ileave_t;

endpackage

// ==== src/pwsi_pwm.sv ====
`timescale 1ns/1ns
`default_nettype none
module pwsi_pwm
  import pwsi_pkg::*;
#(
  parameter int CW = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         sd_fall,
  input  wire pwsi_ileave_t ileave,
  input  wire logic [7:0]   duty,
  input  wire logic [3:0]   chan_en,
  input  wire logic         run,
  output logic [3:0]        pwm_out
);

  function automatic logic [CW-1:0] frac(input logic [CW-1:0] span,
                                         input logic [7:0]    num,
                                         input int            sh);
    logic [CW+7:0] p;
    p = span * num;
    frac = CW'(p >> sh);
  endfunction

  logic [CW-1:0] pos_reg, period_reg, cnt_reg, cyc, delay, on_time;
  logic          started_reg;

  assign cyc     = ileave.fast ? (period_reg >> 1) : period_reg;
  assign delay   = frac(period_reg, {4'h0, ileave.code}, ILV_PHASE_SHIFT);
  assign on_time = frac(cyc, duty, DUTY_SHIFT);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pos_reg    <= '0;
      period_reg <= CW'(SYNC_PERIOD_CYC);
    end else if (sd_fall) begin
      pos_reg    <= '0;
      period_reg <= pos_reg + 1'b1;
    end else if (pos_reg != '1) begin
      pos_reg <= pos_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg     <= '0;
      started_reg <= 1'b0;
    end else if (pos_reg == delay) begin
      cnt_reg     <= '0;
      started_reg <= 1'b1;
    end else if (cnt_reg >= cyc - 1'b1) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwm_out <= 4'h0;
    end else begin
      pwm_out <= chan_en & {4{run & started_reg & (cnt_reg < on_time)}};
    end
  end

endmodule
`default_nettype wire

// ==== src/pwsi_okline.sv ====
`timescale 1ns/1ns
`default_nettype none
module pwsi_okline
  import pwsi_pkg::*;
(
  input  wire logic      sync_clk,
  input  wire logic      rst,
  input  wire logic      tx_req,
  input  wire pwsi_off_t tx_kind,
  input  wire logic      ok_i,
  output logic           ok_oe,
  output logic           rx_toggle,
  output pwsi_off_t      rx_kind
);

  typedef enum logic [7:0] {
    LK_IDLE  = 8'h01,
    LK_START = 8'h02,
    LK_TB1   = 8'h04,
    LK_TB0   = 8'h08,
    LK_HOLD  = 8'h10,
    LK_RB1   = 8'h20,
    LK_RB0   = 8'h40,
    LK_DONE  = 8'h80
  } pwsi_lk_state_t;

  pwsi_lk_state_t state_reg;
  logic           rst_m_reg, rst_l_reg, req_m_reg, req_s_reg;
  logic           ok_m_reg, ok_s_reg, ok_d_reg, rb1_reg;
  pwsi_off_t      kind_reg;

  always_ff @(negedge sync_clk) begin
    rst_m_reg <= rst;
    rst_l_reg <= rst_m_reg;
    req_m_reg <= tx_req;
    req_s_reg <= req_m_reg;
    ok_m_reg  <= ok_i;
    ok_s_reg  <= ok_m_reg;
    ok_d_reg  <= ok_s_reg;
  end

  // line changes on falling sync edge
  always_ff @(negedge sync_clk) begin
    if (rst_l_reg) begin
      state_reg <= LK_IDLE;
      ok_oe     <= 1'b0;
      kind_reg  <= OFF_SEQ;
      rb1_reg   <= 1'b0;
      rx_toggle <= 1'b0;
      rx_kind   <= OFF_SEQ;
    end else begin
      case (state_reg)
        LK_IDLE: begin
          if (req_s_reg) begin
            kind_reg  <= tx_kind;
            ok_oe     <= 1'b1;
            state_reg <= LK_START;
          end else if (ok_d_reg & ~ok_s_reg) begin
            state_reg <= LK_RB1;
          end
        end
        LK_START: begin
          ok_oe     <= ~kind_reg[1];
          state_reg <= LK_TB1;
        end
        LK_TB1: begin
          ok_oe     <= ~kind_reg[0];
          state_reg <= LK_TB0;
        end
        LK_TB0: begin
          ok_oe     <= 1'b1;
          state_reg <= LK_HOLD;
        end
        LK_HOLD: begin
          if (!req_s_reg) begin
            ok_oe     <= 1'b0;
            state_reg <= LK_IDLE;
          end
        end
        LK_RB1: begin
          rb1_reg   <= ok_s_reg;
          state_reg <= LK_RB0;
        end
        LK_RB0: begin
          rx_kind   <= pwsi_off_t'({rb1_reg, ok_s_reg});
          rx_toggle <= ~rx_toggle;
          state_reg <= LK_DONE;
        end
        LK_DONE: begin
          if (ok_s_reg) begin
            state_reg <= LK_IDLE;
          end
        end
        default: begin
          ok_oe     <= 1'b0;
          state_reg <= LK_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== src/pwsi_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module pwsi_top
  import pwsi_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = I2C_DEV_ADDR_DFLT,
  parameter int         CW       = 8
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        sync_clk,
  input  wire logic        ok_i,
  output logic             ok_o,
  output logic             ok_oe,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire pwsi_mon_t   mon_pins,
  input  wire pwsi_stage_t stage_pins,
  input  wire logic [1:0]  phase_count_pins,
  input  wire logic        tr_enable,
  input  wire logic [4:0]  prop_enable,
  input  wire logic        ot_crit_sel,
  input  wire logic        uv_crit_sel,
  input  wire logic        ov_emrg_sel,
  input  wire logic        restart,
  input  wire logic [7:0]  duty_cmd,
  output logic [3:0]       pwm_out,
  output logic             fast_off,
  output logic             regular_off,
  output logic             low_side_on,
  output pwsi_mon_t        fault_status,
  output logic             output_in_regulation_flag
);

  localparam int SW = 26;

  typedef enum logic [8:0] {
    I2C_IDLE = 9'h001,
    I2C_ADDR = 9'h002,
    I2C_AACK = 9'h004,
    I2C_PTR  = 9'h008,
    I2C_PACK = 9'h010,
    I2C_WDAT = 9'h020,
    I2C_WACK = 9'h040,
    I2C_RDAT = 9'h080,
    I2C_RACK = 9'h100
  } pwsi_i2c_state_t;

  function automatic logic [3:0] chan_mask(input logic [1:0] phs);
    case (phs)
      2'h0:    chan_mask = 4'h1;
      2'h1:    chan_mask = 4'h5;
      2'h2:    chan_mask = 4'h7;
      default: chan_mask = 4'hF;
    endcase
  endfunction

  // Input synchronisers
  logic [SW-1:0] sync_m_reg, sync_s_reg;
  logic          scl_s, sda_s, sd_s, tr_en_s, ot_crit_s, uv_crit_s;
  logic          ov_emrg_s, restart_s;
  logic [1:0]    phs_s;
  logic [4:0]    prop_s;
  pwsi_mon_t     mon_s;
  pwsi_stage_t   stage_s;

  always_ff @(posedge core_clk) begin
    sync_m_reg <= {scl_i, sda_i, sync_clk, mon_pins, stage_pins,
                   phase_count_pins, tr_enable, prop_enable, ot_crit_sel,
                   uv_crit_sel, ov_emrg_sel, restart};
    sync_s_reg <= sync_m_reg;
  end

  assign {scl_s, sda_s, sd_s, mon_s, stage_s, phs_s, tr_en_s, prop_s,
          ot_crit_s, uv_crit_s, ov_emrg_s, restart_s} = sync_s_reg;

  // Serial register port
  pwsi_i2c_state_t i2c_state_reg;
  logic            scl_d_reg, sda_d_reg, sd_d_reg, rw_reg;
  logic [3:0]      bit_cnt_reg;
  logic [7:0]      shift_reg, ptr_reg, read_val;
  logic            scl_rise, scl_fall, bus_start, bus_stop, wr_hit;
  pwsi_ileave_t    ileave_reg;
  logic [1:0]      phs_reg;

  always_ff @(posedge core_clk) begin
    scl_d_reg <= scl_s;
    sda_d_reg <= sda_s;
    sd_d_reg  <= sd_s;
  end

  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign wr_hit    = (i2c_state_reg == I2C_WDAT) & scl_fall
                     & (bit_cnt_reg == 4'h8) & (ptr_reg == ILV_REG_ADDR);

  assign read_val = (ptr_reg == ILV_REG_ADDR) ?
                    {phs_reg, ileave_reg.fast, 1'b0, ileave_reg.code} : 8'h00;
  assign sda_o    = 1'b0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      i2c_state_reg <= I2C_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      ptr_reg       <= 8'h00;
      rw_reg        <= 1'b0;
      sda_oe        <= 1'b0;
    end else if (bus_start) begin
      i2c_state_reg <= I2C_ADDR;
      bit_cnt_reg   <= 4'h0;
      sda_oe        <= 1'b0;
    end else if (bus_stop) begin
      i2c_state_reg <= I2C_IDLE;
      sda_oe        <= 1'b0;
    end else begin
      case (i2c_state_reg)
        I2C_IDLE: begin
          sda_oe <= 1'b0;
        end
        I2C_ADDR, I2C_PTR, I2C_WDAT: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            sda_oe      <= 1'b1;
            if (i2c_state_reg == I2C_ADDR) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                rw_reg        <= shift_reg[0];
                i2c_state_reg <= I2C_AACK;
              end else begin
                sda_oe        <= 1'b0;
                i2c_state_reg <= I2C_IDLE;
              end
            end else if (i2c_state_reg == I2C_PTR) begin
              ptr_reg       <= shift_reg;
              i2c_state_reg <= I2C_PACK;
            end else begin
              i2c_state_reg <= I2C_WACK;
            end
          end
        end
        I2C_AACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              shift_reg     <= read_val;
              sda_oe        <= ~read_val[7];
              i2c_state_reg <= I2C_RDAT;
            end else begin
              sda_oe        <= 1'b0;
              i2c_state_reg <= I2C_PTR;
            end
          end
        end
        I2C_PACK, I2C_WACK: begin
          if (scl_fall) begin
            sda_oe        <= 1'b0;
            i2c_state_reg <= I2C_WDAT;
          end
        end
        I2C_RDAT: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              bit_cnt_reg   <= 4'h0;
              sda_oe        <= 1'b0;
              i2c_state_reg <= I2C_RACK;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              shift_reg   <= {shift_reg[6:0], 1'b0};
              sda_oe      <= ~shift_reg[6];
            end
          end
        end
        I2C_RACK: begin
          if (scl_rise && sda_s) begin
            i2c_state_reg <= I2C_IDLE;
          end else if (scl_fall) begin
            shift_reg     <= read_val;
            sda_oe        <= ~read_val[7];
            i2c_state_reg <= I2C_RDAT;
          end
        end
        default: begin
          sda_oe        <= 1'b0;
          i2c_state_reg <= I2C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ileave_reg.fast <= ILV_REG_RESET[ILV_FREQ_BIT];
      ileave_reg.code <= ILV_REG_RESET[ILV_CODE_LSB +: ILV_CODE_W];
    end else if (wr_hit) begin
      ileave_reg.fast <= shift_reg[ILV_FREQ_BIT];
      ileave_reg.code <= shift_reg[ILV_CODE_LSB +: ILV_CODE_W];
    end
  end

  // Phase count taken from straps while in reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phs_reg <= phs_s;
    end
  end

  // Fault supervision
  pwsi_mon_t act, flags_reg;
  logic      local_fast, local_reg, prop_crit, prop_emrg, prop_seq;
  logic      tx_want_reg, tx_req_reg;
  pwsi_off_t tx_kind_reg;

  always_comb begin
    act = '0;
    act.tw = stage_s.vin_ok & mon_s.tw;
    act.ot = stage_s.vin_ok & mon_s.ot;
    act.tr = stage_s.ramp & mon_s.tr & tr_en_s;
    act.uv = stage_s.steady & mon_s.uv;
    act.pg = stage_s.steady & mon_s.pg;
    act.oc = stage_s.above_prebias & mon_s.oc;
    act.ov = stage_s.above_prebias & mon_s.ov;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (restart_s ? '0 : flags_reg) | act;
    end
  end

  assign local_fast = flags_reg.tr | flags_reg.oc | flags_reg.ov;
  assign local_reg  = flags_reg.ot | flags_reg.uv;

  assign prop_emrg = flags_reg.ov & prop_s[0] & ov_emrg_s;
  assign prop_crit = (flags_reg.tr & prop_s[4]) | (flags_reg.oc & prop_s[2])
                     | (flags_reg.ov & prop_s[0] & ~ov_emrg_s)
                     | (flags_reg.ot & prop_s[3] & ot_crit_s)
                     | (flags_reg.uv & prop_s[1] & uv_crit_s);
  assign prop_seq  = (flags_reg.ot & prop_s[3]) | (flags_reg.uv & prop_s[1]);

  // Kind settles one cycle before the request rises
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_kind_reg <= OFF_SEQ;
      tx_want_reg <= 1'b0;
      tx_req_reg  <= 1'b0;
    end else begin
      tx_kind_reg <= prop_emrg ? OFF_EMRG : (prop_crit ? OFF_CRIT : OFF_SEQ);
      tx_want_reg <= prop_emrg | prop_crit | prop_seq;
      tx_req_reg  <= tx_want_reg;
    end
  end

  // Group line link
  logic      rx_toggle, rx_t_m_reg, rx_t_s_reg, rx_t_d_reg;
  logic      grp_hit_reg;
  pwsi_off_t rx_kind, grp_kind_reg;

  pwsi_okline u_okline (
    .sync_clk  (sync_clk),
    .rst       (rst),
    .tx_req    (tx_req_reg),
    .tx_kind   (tx_kind_reg),
    .ok_i      (ok_i),
    .ok_oe     (ok_oe),
    .rx_toggle (rx_toggle),
    .rx_kind   (rx_kind)
  );

  assign ok_o = 1'b0;

  always_ff @(posedge core_clk) begin
    rx_t_m_reg <= rx_toggle;
    rx_t_s_reg <= rx_t_m_reg;
    rx_t_d_reg <= rx_t_s_reg;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      grp_hit_reg  <= 1'b0;
      grp_kind_reg <= OFF_SEQ;
    end else if (rx_t_s_reg ^ rx_t_d_reg) begin
      grp_hit_reg  <= 1'b1;
      grp_kind_reg <= rx_kind;
    end else if (restart_s) begin
      grp_hit_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      fast_off                  <= 1'b0;
      regular_off               <= 1'b0;
      low_side_on               <= 1'b0;
      fault_status              <= '0;
      output_in_regulation_flag <= 1'b0;
    end else begin
      fast_off    <= local_fast | (grp_hit_reg & (grp_kind_reg != OFF_SEQ));
      regular_off <= (local_reg | (grp_hit_reg & (grp_kind_reg == OFF_SEQ)))
                     & ~local_fast;
      low_side_on <= flags_reg.ov | (grp_hit_reg & (grp_kind_reg == OFF_EMRG));
      fault_status <= flags_reg;
      output_in_regulation_flag <= act.pg;
    end
  end

  pwsi_pwm #(
    .CW (CW)
  ) u_pwm (
    .core_clk (core_clk),
    .rst      (rst),
    .sd_fall  (sd_d_reg & ~sd_s),
    .ileave   (ileave_reg),
    .duty     (duty_cmd),
    .chan_en  (chan_mask(phs_reg)),
    .run      (~(fast_off | regular_off)),
    .pwm_out  (pwm_out)
  );

endmodule
`default_nettype wire

// ==== testbench/pwsi_top_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module pwsi_top_sva
  import pwsi_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        sync_clk,
  input wire logic        ok_o,
  input wire logic        ok_oe,
  input wire pwsi_stage_t stage_pins,
  input wire logic [1:0]  phase_count_pins,
  input wire logic [3:0]  pwm_out,
  input wire logic        fast_off,
  input wire logic        regular_off,
  input wire logic        low_side_on,
  input wire pwsi_mon_t   fault_status,
  input wire logic        output_in_regulation_flag
);
  logic [1:0] pc_reg;
  logic       oe_neg_reg;
  logic [3:0] mask;

  // Strap captured while reset is high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_reg <= phase_count_pins;
    end
  end

  // Level seen mid-period, compared at the next falling edge
  always_ff @(posedge sync_clk) begin
    oe_neg_reg <= ok_oe;
  end

  assign mask = (pc_reg == 2'h0) ? 4'h1 : (pc_reg == 2'h1) ? 4'h5 :
                (pc_reg == 2'h2) ? 4'h7 : 4'hF;

  sequence off_held_s;
    (fast_off || regular_off) [*2];
  endsequence

  sequence unsteady_s;
    !stage_pins.steady [*4];
  endsequence

  okoe_edge_a: assert property (
    @(negedge sync_clk) disable iff (rst) ok_oe == oe_neg_reg)
    else $error("group line moved off the falling sync edge");
  ok_drive_a: assert property (
    @(posedge core_clk) disable iff (rst) ok_o == 1'b0)
    else $error("group line driven high");
  okoe_cause_a: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(ok_oe) |-> fault_status[4:0] != 5'h00)
    else $error("group line pulled without a fault");
  lowside_fast_a: assert property (
    @(posedge core_clk) disable iff (rst) low_side_on |-> fast_off)
    else $error("low-side held on without fast turn-off");
  pwm_halt_a: assert property (
    @(posedge core_clk) disable iff (rst) off_held_s |-> pwm_out == 4'h0)
    else $error("pwm running during turn-off");
  chan_mask_a: assert property (
    @(posedge core_clk) disable iff (rst) (pwm_out & ~mask) == 4'h0)
    else $error("inactive pwm channel toggling");
  good_stage_a: assert property (
    @(posedge core_clk) disable iff (rst)
    unsteady_s |-> !output_in_regulation_flag)
    else $error("regulation flag outside steady state");
  oc_armed_a: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(fault_status.oc) |-> stage_pins.above_prebias)
    else $error("overcurrent flagged below pre-bias");
  reset_quiet_a: assert property (
    @(posedge core_clk) disable iff (rst)
    $fell(rst) |-> pwm_out == 4'h0 && !fast_off && !regular_off)
    else $error("outputs active after reset");
endmodule

bind pwsi_top pwsi_top_sva i_pwsi_top_sva (
  .core_clk, .rst, .sync_clk, .ok_o, .ok_oe, .stage_pins,
  .phase_count_pins, .pwm_out, .fast_off, .regular_off, .low_side_on,
  .fault_status, .output_in_regulation_flag
);
`default_nettype wire

// ==== testbench/pwsi_mgr_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module pwsi_mgr_model
  import pwsi_pkg::*;
(
  output logic           sync_clk,
  input  wire logic      send,
  input  wire pwsi_off_t kind,
  input  wire logic      ok_line,
  output logic           mgr_oe,
  output pwsi_off_t      seen_kind
);
  logic [1:0] slot_reg;
  logic [1:0] rx_cnt_reg;
  logic       ok_prev_reg;
  logic       bit1_reg;

  initial begin
    sync_clk    = 1'b1;
    mgr_oe      = 1'b0;
    slot_reg    = 2'h0;
    rx_cnt_reg  = 2'h0;
    ok_prev_reg = 1'b1;
    bit1_reg    = 1'b0;
    seen_kind   = OFF_SEQ;
    #7;
    forever #32 sync_clk = ~sync_clk;
  end

  // start slot, kind bits, then hold low
  always @(negedge sync_clk) begin
    if (!send) begin
      mgr_oe   <= 1'b0;
      slot_reg <= 2'h0;
    end else begin
      mgr_oe   <= (slot_reg == 2'h1) ? !kind[1] :
                  (slot_reg == 2'h2) ? !kind[0] : 1'b1;
      slot_reg <= (slot_reg == 2'h3) ? 2'h3 : slot_reg + 2'h1;
    end
  end

  // decode kind unaltered from the line
  always @(negedge sync_clk) begin
    ok_prev_reg <= ok_line;
    if (!send) begin
      if (rx_cnt_reg == 2'h0) begin
        rx_cnt_reg <= (ok_prev_reg === 1'b1 && ok_line === 1'b0) ? 2'h1
                                                                 : 2'h0;
      end else if (rx_cnt_reg == 2'h1) begin
        bit1_reg   <= ok_line;
        rx_cnt_reg <= 2'h2;
      end else if (rx_cnt_reg == 2'h2) begin
        seen_kind  <= pwsi_off_t'({bit1_reg, ok_line});
        rx_cnt_reg <= 2'h3;
      end else if (ok_line) begin
        rx_cnt_reg <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/pwsi_top_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module pwsi_top_tb_top
  import pwsi_pkg::*;
();
  logic        core_clk, rst, sync_clk, ok_i, ok_oe, mgr_oe, send;
  logic        scl_i, sda_i, sda_oe, sda_m_oe, restart, tr_enable;
  logic        ot_crit_sel, uv_crit_sel, ov_emrg_sel;
  logic        fast_off, regular_off, low_side_on;
  logic        output_in_regulation_flag;
  pwsi_mon_t   mon_pins, fault_status;
  pwsi_stage_t stage_pins;
  pwsi_off_t   kind, seen_kind;
  logic [1:0]  phase_count_pins;
  logic [4:0]  prop_enable;
  logic [7:0]  duty_cmd, offs;
  logic [3:0]  pwm_out;
  int          bad_count, num_checks;

  localparam logic [14:0] ROWS [9] = '{
    {7'h60, 4'hB, 4'h8}, {7'h10, 4'hD, 4'hC}, {7'h10, 4'hD, 4'h0},
    {7'h08, 4'h8, 4'hA}, {7'h04, 4'h9, 4'hC}, {7'h04, 4'h8, 4'h8},
    {7'h02, 4'hB, 4'hA}, {7'h02, 4'hD, 4'h8}, {7'h01, 4'h9, 4'hD}};
  localparam logic [10:0] PROP [4] = '{
    {7'h01, 4'hA}, {7'h01, 4'h1}, {7'h02, 4'h0}, {7'h02, 4'h5}};
  localparam logic [7:0]  RECV [3] = '{8'h02, 8'h04, 8'h05};

  assign ok_i  = ~(ok_oe | mgr_oe);
  assign sda_i = ~(sda_oe | sda_m_oe);
  assign offs  = {5'h00, fast_off, regular_off, low_side_on};

  pwsi_top i_pwsi_top (
    .core_clk, .rst, .sync_clk, .ok_i, .ok_o(), .ok_oe, .scl_i, .sda_i,
    .sda_o(), .sda_oe, .mon_pins, .stage_pins, .phase_count_pins,
    .tr_enable, .prop_enable, .ot_crit_sel, .uv_crit_sel, .ov_emrg_sel,
    .restart, .duty_cmd, .pwm_out, .fast_off, .regular_off, .low_side_on,
    .fault_status, .output_in_regulation_flag
  );

  pwsi_mgr_model i_pwsi_mgr_model (
    .sync_clk, .send, .kind, .ok_line(ok_i), .mgr_oe, .seen_kind
  );

  always #50 core_clk = ~core_clk;

  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Start when stop is 0, stop when 1
  task automatic cond(input logic stop);
    sda_m_oe <= stop;
    tk(6);
    scl_i    <= 1'b1;
    tk(6);
    sda_m_oe <= !stop;
    tk(6);
    scl_i    <= stop;
    tk(6);
  endtask

  task automatic sbit(input logic b, output logic r);
    sda_m_oe <= !b;
    tk(6);
    scl_i    <= 1'b1;
    tk(6);
    r = sda_i;
    scl_i    <= 1'b0;
    tk(6);
  endtask

  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sbit(d[i], q[i]);
    end
    sbit(last, ack);
  endtask

  task automatic wbyte(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    xfer(d, 1'b1, q, a);
    chk({7'h00, a}, 8'h00);
  endtask

  task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
    cond(1'b0);
    wbyte({I2C_DEV_ADDR_DFLT, 1'b0});
    wbyte(p);
    wbyte(d);
    cond(1'b1);
  endtask

  task automatic reg_rd(input logic [7:0] p, output logic [7:0] q);
    logic a;
    cond(1'b0);
    wbyte({I2C_DEV_ADDR_DFLT, 1'b0});
    wbyte(p);
    cond(1'b0);
    wbyte({I2C_DEV_ADDR_DFLT, 1'b1});
    xfer(8'hFF, 1'b1, q, a);
    cond(1'b1);
  endtask

  task automatic t_regs();
    logic [7:0] q;
    logic       a;
    reg_rd(ILV_REG_ADDR, q);
    chk(q, 8'h80);
    reg_wr(ILV_REG_ADDR, 8'h3F);
    reg_rd(ILV_REG_ADDR, q);
    chk(q, 8'hAF);
    reg_wr(8'h07, 8'h55);
    reg_rd(8'h07, q);
    chk(q, 8'h00);
    cond(1'b0);
    xfer({7'h15, 1'b0}, 1'b1, q, a);
    chk({7'h00, a}, 8'h01);
    cond(1'b1);
    reg_wr(ILV_REG_ADDR, 8'h00);
  endtask

  task automatic clear();
    mon_pins <= '0;
    send     <= 1'b0;
    restart  <= 1'b1;
    tk(8);
    restart  <= 1'b0;
    tk(20);
  endtask

  task automatic t_faults();
    for (int i = 0; i < 9; i++) begin
      mon_pins   <= ROWS[i][14:8];
      stage_pins <= ROWS[i][7:4];
      tr_enable  <= ROWS[i][3];
      tk(12);
      chk(offs, {5'h00, ROWS[i][2:0]});
      if (i == 0) begin
        chk({6'h00, fault_status.tw, output_in_regulation_flag}, 8'h03);
      end
      clear();
    end
  endtask

  task automatic t_prop();
    prop_enable <= 5'h1F;
    stage_pins  <= 4'hB;
    for (int i = 0; i < 4; i++) begin
      ov_emrg_sel <= PROP[i][3];
      uv_crit_sel <= PROP[i][2];
      tk(4);
      mon_pins <= PROP[i][10:4];
      tk(60);
      chk({6'h00, seen_kind}, {6'h00, PROP[i][1:0]});
      clear();
    end
  endtask

  task automatic t_recv();
    for (int i = 0; i < 3; i++) begin
      kind <= pwsi_off_t'(i[1:0]);
      send <= 1'b1;
      tk(60);
      chk(offs, RECV[i]);
      chk({7'h00, ok_oe}, 8'h00);
      clear();
    end
  endtask

  initial begin
    tk(20000);
    bad_count++;
    wrap_up();
  end

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    scl_i = 1'b1;
    sda_m_oe = 1'b0;
    restart = 1'b0;
    tr_enable = 1'b1;
    ot_crit_sel = 1'b0;
    uv_crit_sel = 1'b0;
    ov_emrg_sel = 1'b0;
    send = 1'b0;
    kind = OFF_SEQ;
    mon_pins = '0;
    stage_pins = 4'hB;
    phase_count_pins = 2'h2;
    prop_enable = 5'h00;
    duty_cmd = 8'h80;
    bad_count = 0;
    num_checks = 0;
    tk(12);
    rst <= 1'b0;
    tk(4);
    t_regs();
    t_faults();
    t_prop();
    t_recv();
    wrap_up();
  end
endmodule
`default_nettype wire
